//--- rtl/aspc_err_mon.sv
`timescale 1ns/1ps
module aspc_err_mon (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic detectOn,
    input wire logic bitEdge,
    input wire logic frameStart,
    output logic busError,
    output logic goodFrame
);
    logic [15:0] idleCount;
    logic [9:0] bitCount;
    logic [9:0] lastLength;
    logic lengthKnown;
    logic frameSeen;
    logic idleTimeout;

    assign idleTimeout = idleCount >= 16'(aspc_pkg::BIT_CLOCK_TIMEOUT_CYC);

    // cycles since the last bit clock edge, saturating
    always_ff @(posedge clk) begin
        if (sys_rst || bitEdge || !detectOn) begin
            idleCount <= 16'h0000;
        end else if (!idleTimeout) begin
            idleCount <= idleCount + 16'h0001;
        end
    end

    // frame length in bit clocks, compared frame to frame
    // the first start only opens counting, so a cut first frame sets no length
    always_ff @(posedge clk) begin
        if (sys_rst || !detectOn) begin
            bitCount <= 10'h000;
            lastLength <= 10'h000;
            lengthKnown <= 1'b0;
            frameSeen <= 1'b0;
            goodFrame <= 1'b0;
        end else begin
            goodFrame <= 1'b0;
            if (frameStart) begin
                goodFrame <= lengthKnown && bitCount == lastLength;
                lastLength <= bitCount;
                lengthKnown <= frameSeen;
                frameSeen <= 1'b1;
                bitCount <= 10'h001;
            end else if (bitEdge && bitCount != 10'h3FF) begin
                bitCount <= bitCount + 10'h001;
            end
        end
    end

    // error on a stalled clock or a frame of changed length
    always_ff @(posedge clk) begin
        if (sys_rst || !detectOn) begin
            busError <= 1'b0;
        end else if (idleTimeout) begin
            busError <= 1'b1;
        end else if (frameStart && lengthKnown && bitCount != lastLength) begin
            busError <= 1'b1;
        end else if (goodFrame) begin
            busError <= 1'b0;
        end
    end
endmodule

//--- rtl/aspc_pkg.sv
package aspc_pkg;
    // clock and link timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int BIT_CLOCK_TIMEOUT_NS = 2000;
    localparam int BIT_CLOCK_TIMEOUT_CYC = BIT_CLOCK_TIMEOUT_NS / CLK_PERIOD_NS;

    // register offsets
    localparam logic [7:0] ADDR_ENABLE_DAISY = 8'h18;
    localparam logic [7:0] ADDR_LANE_CONFIG = 8'h19;
    localparam logic [7:0] ADDR_PRIMARY_FORMAT = 8'h1A;
    localparam logic [7:0] ADDR_PRIMARY_TRANSMIT = 8'h1B;
    localparam logic [7:0] ADDR_SECONDARY_FORMAT = 8'h30;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h31;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h32;
    localparam logic [7:0] ADDR_PORT_STATUS = 8'h33;

    // reset values and the lane write mask
    localparam logic [7:0] RST_ENABLE_DAISY = 8'h40;
    localparam logic [7:0] RST_LANE_CONFIG = 8'h00;
    localparam logic [7:0] RST_PRIMARY_FORMAT = 8'h30;
    localparam logic [7:0] RST_PRIMARY_TRANSMIT = 8'h00;
    localparam logic [7:0] RST_SECONDARY_FORMAT = 8'h30;
    localparam logic [2:0] RST_IRQ_MASK = 3'h0;
    localparam logic [7:0] LANE_WRITE_MASK = 8'hFE;

    // field positions, enable and daisy register
    localparam int PRIMARY_DISABLE_BIT = 7;
    localparam int SECONDARY_DISABLE_BIT = 6;
    localparam int FOLLOW_PRIMARY_BIT = 5;
    localparam int DAISY_MODE_LSB = 3;
    localparam int DAISY_INPUT_LSB = 0;
    // field positions, lane register
    localparam int OUTPUT_LANE_LSB = 6;
    localparam int INPUT_LANE_LSB = 4;
    localparam int DAISY_DIRECTION_BIT = 3;
    // field positions, format register
    localparam int PROTOCOL_LSB = 6;
    localparam int SLOT_LENGTH_LSB = 4;
    localparam int FRAME_INVERT_BIT = 3;
    localparam int BIT_CLOCK_INVERT_BIT = 2;
    localparam int ERROR_DETECT_OFF_BIT = 1;
    localparam int NO_AUTORESUME_BIT = 0;
    // interrupt status bits
    localparam int IRQ_ERROR_SET_BIT = 0;
    localparam int IRQ_ERROR_CLEAR_BIT = 1;
    localparam int IRQ_RX_WORD_BIT = 2;

    // field codes
    localparam logic [1:0] PROTOCOL_TDM = 2'h0;
    localparam logic [1:0] PROTOCOL_I2S = 2'h1;
    localparam logic [1:0] PROTOCOL_LJ = 2'h2;
    localparam logic [1:0] DAISY_OFF = 2'h0;
    localparam logic [1:0] DAISY_PRIMARY = 2'h1;
    localparam logic [1:0] DAISY_SECONDARY = 2'h2;
    localparam logic [1:0] LANE_SPLIT = 2'h0;
    localparam logic [1:0] LANE_PRIMARY_TWO = 2'h1;
    localparam logic [1:0] LANE_SECONDARY_TWO = 2'h2;
    localparam logic [2:0] DAISY_IN_OFF = 3'h0;
    localparam logic [2:0] DAISY_IN_GENERAL_ONE = 3'h1;
    localparam logic [2:0] DAISY_IN_GENERAL_TWO = 3'h2;
    localparam logic [2:0] DAISY_IN_INPUT_ONE = 3'h3;
    localparam logic [2:0] DAISY_IN_DATA_IN = 3'h5;

    // primary port run state
    typedef enum logic [2:0] {
        RUN_ACTIVE = 3'b001,
        RUN_HALTED = 3'b010,
        RUN_LOCKED = 3'b100
    } aspc_run_t;
endpackage

//--- rtl/aspc_sync.sv
`timescale 1ns/1ps
module aspc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stageOne;

    // two flops per bit; only the second stage is ever read
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    stageOne[i] <= 1'b0;
                    syncOut[i] <= 1'b0;
                end else begin
                    stageOne[i] <= asyncIn[i];
                    syncOut[i] <= stageOne[i];
                end
            end
        end
    endgenerate
endmodule

//--- rtl/aspc_top.sv
`timescale 1ns/1ps
module aspc_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    input wire logic pinBitClock,
    input wire logic pinFrameSync,
    input wire logic pinDataIn,
    input wire logic pinGeneralOne,
    input wire logic pinGeneralTwo,
    input wire logic pinGeneralInputOne,
    output logic pinDataOut,
    output logic pinDataOutEnable,
    input wire logic [31:0] txWord,
    output logic txTake,
    output logic [31:0] rxWord,
    output logic rxValid,
    output logic primaryActive,
    output logic secondaryActive,
    output logic [1:0] secondaryProtocol,
    output logic [1:0] secondarySlotLength,
    output logic secondaryFrameInvert,
    output logic secondaryBitInvert,
    output logic primaryTwoOut,
    output logic secondaryTwoOut,
    output logic primaryTwoIn,
    output logic secondaryTwoIn,
    output logic daisyPrimary,
    output logic daisySecondary,
    output logic daisyThroughInput,
    output logic daisyData,
    output logic irq
);
    logic [7:0] enableDaisy;
    logic [7:0] laneConfig;
    logic [7:0] primaryFormat;
    logic [7:0] primaryTransmit;
    logic [7:0] secondaryFormat;
    logic [2:0] irqStatus;
    logic [2:0] irqMask;
    logic [2:0] irqEvent;
    aspc_pkg::aspc_run_t runState;
    aspc_pkg::aspc_run_t next_runState;

    logic [5:0] pinSync;
    logic bitClockS, frameSyncS, dataInS, generalOneS, generalTwoS, inputOneS;
    logic bitClockLast, frameLast;
    logic bitEff, frameEff, sampleEdge, driveEdge, frameStart;
    logic busError, goodFrame, busErrorLast, reconfigWrite;
    logic [1:0] protocol, daisyMode, outLanes, inLanes;
    logic [2:0] daisySelect;
    logic [5:0] slotBits;
    logic primaryEnabled, primaryRunning, detectOn, inFrame;
    logic [5:0] bitIndex;
    logic [31:0] rxShift;
    logic [31:0] txShift;

    // slot length code to bit count
    function automatic logic [5:0] slot_bits(input logic [1:0] code);
        case (code)
            2'h0: slot_bits = 6'h10;
            2'h1: slot_bits = 6'h14;
            2'h2: slot_bits = 6'h18;
            default: slot_bits = 6'h20;
        endcase
    endfunction

    // reserved two-bit codes act as the plain default
    function automatic logic [1:0] legal_code(input logic [1:0] code);
        legal_code = (code == 2'h3) ? 2'h0 : code;
    endfunction

    // pins come from the link's clock domain
    aspc_sync #(
        .WIDTH(6)
    ) u_pin_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .asyncIn({pinBitClock, pinFrameSync, pinDataIn, pinGeneralOne, pinGeneralTwo,
            pinGeneralInputOne}),
        .syncOut(pinSync)
    );
    assign {bitClockS, frameSyncS, dataInS, generalOneS, generalTwoS, inputOneS} = pinSync;

    // field decode
    assign protocol = legal_code(primaryFormat[aspc_pkg::PROTOCOL_LSB +: 2]);
    assign slotBits = slot_bits(primaryFormat[aspc_pkg::SLOT_LENGTH_LSB +: 2]);
    assign daisyMode = legal_code(enableDaisy[aspc_pkg::DAISY_MODE_LSB +: 2]);
    assign daisySelect = enableDaisy[aspc_pkg::DAISY_INPUT_LSB +: 3];
    assign outLanes = legal_code(laneConfig[aspc_pkg::OUTPUT_LANE_LSB +: 2]);
    assign inLanes = legal_code(laneConfig[aspc_pkg::INPUT_LANE_LSB +: 2]);

    // a chained secondary port removes the primary port
    assign primaryEnabled = !enableDaisy[aspc_pkg::PRIMARY_DISABLE_BIT]
        && daisyMode != aspc_pkg::DAISY_SECONDARY;
    assign primaryRunning = primaryEnabled && runState == aspc_pkg::RUN_ACTIVE;
    assign detectOn = primaryEnabled
        && !primaryFormat[aspc_pkg::ERROR_DETECT_OFF_BIT];

    // polarity applied before edge detection; I2S frames open on the low half
    assign bitEff = bitClockS ^ primaryFormat[aspc_pkg::BIT_CLOCK_INVERT_BIT];
    assign frameEff = frameSyncS ^ primaryFormat[aspc_pkg::FRAME_INVERT_BIT]
        ^ (protocol == aspc_pkg::PROTOCOL_I2S);
    assign sampleEdge = bitEff && !bitClockLast;
    assign driveEdge = !bitEff && bitClockLast;
    assign frameStart = sampleEdge && frameEff && !frameLast;

    // edge history on the effective link levels
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bitClockLast <= 1'b0;
            frameLast <= 1'b0;
        end else begin
            bitClockLast <= bitEff;
            if (sampleEdge) begin
                frameLast <= frameEff;
            end
        end
    end

    aspc_err_mon u_err_mon (
        .clk(clk),
        .sys_rst(sys_rst),
        .detectOn(detectOn),
        .bitEdge(sampleEdge),
        .frameStart(frameStart),
        .busError(busError),
        .goodFrame(goodFrame)
    );

    // any write to the primary setup counts as the host reconfiguring
    assign reconfigWrite = regWrite && (regAddr == aspc_pkg::ADDR_ENABLE_DAISY
        || regAddr == aspc_pkg::ADDR_PRIMARY_FORMAT
        || regAddr == aspc_pkg::ADDR_PRIMARY_TRANSMIT);

    // error recovery: halted ports come back by themselves, locked ones by the host
    always_comb begin
        next_runState = runState;
        case (runState)
            aspc_pkg::RUN_ACTIVE: begin
                if (busError) begin
                    next_runState = primaryFormat[aspc_pkg::NO_AUTORESUME_BIT]
                        ? aspc_pkg::RUN_LOCKED : aspc_pkg::RUN_HALTED;
                end
            end
            aspc_pkg::RUN_HALTED: begin
                if (!busError) begin
                    next_runState = aspc_pkg::RUN_ACTIVE;
                end
            end
            aspc_pkg::RUN_LOCKED: begin
                if (reconfigWrite) begin
                    next_runState = aspc_pkg::RUN_ACTIVE;
                end
            end
            default: next_runState = aspc_pkg::RUN_ACTIVE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            runState <= aspc_pkg::RUN_ACTIVE;
        end else begin
            runState <= next_runState;
        end
    end

    // receive: I2S skips the bit at the frame edge for its one-bit delay
    always_ff @(posedge clk) begin
        if (sys_rst || !primaryRunning) begin
            inFrame <= 1'b0;
            bitIndex <= 6'h00;
            rxShift <= 32'h0000_0000;
            rxWord <= 32'h0000_0000;
            rxValid <= 1'b0;
        end else begin
            rxValid <= 1'b0;
            if (frameStart) begin
                inFrame <= 1'b1;
                if (protocol == aspc_pkg::PROTOCOL_I2S) begin
                    rxShift <= 32'h0000_0000;
                    bitIndex <= 6'h00;
                end else begin
                    rxShift <= {31'h0000_0000, dataInS};
                    bitIndex <= 6'h01;
                end
            end else if (sampleEdge && inFrame) begin
                if (bitIndex == slotBits - 6'h01) begin
                    rxWord <= {rxShift[30:0], dataInS};
                    rxValid <= 1'b1;
                    rxShift <= 32'h0000_0000;
                    bitIndex <= 6'h00;
                end else begin
                    rxShift <= {rxShift[30:0], dataInS};
                    bitIndex <= bitIndex + 6'h01;
                end
            end
        end
    end

    // transmit: next word fetched at each slot start, msb first on the drive edge
    always_ff @(posedge clk) begin
        if (sys_rst || !primaryRunning) begin
            txShift <= 32'h0000_0000;
            txTake <= 1'b0;
            pinDataOut <= 1'b0;
        end else begin
            txTake <= 1'b0;
            if (sampleEdge && (frameStart || (inFrame && bitIndex == 6'h00))) begin
                txShift <= txWord << (6'h20 - slotBits);
                txTake <= 1'b1;
            end else if (driveEdge && inFrame) begin
                pinDataOut <= txShift[31];
                txShift <= {txShift[30:0], 1'b0};
            end
        end
    end

    // decoded setup for the lanes, the daisy chain and the secondary port
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pinDataOutEnable <= 1'b0;
            primaryActive <= 1'b0;
            secondaryActive <= 1'b0;
            secondaryProtocol <= 2'h0;
            secondarySlotLength <= 2'h0;
            secondaryFrameInvert <= 1'b0;
            secondaryBitInvert <= 1'b0;
            primaryTwoOut <= 1'b0;
            secondaryTwoOut <= 1'b0;
            primaryTwoIn <= 1'b0;
            secondaryTwoIn <= 1'b0;
            daisyPrimary <= 1'b0;
            daisySecondary <= 1'b0;
            daisyThroughInput <= 1'b0;
            daisyData <= 1'b0;
        end else begin
            pinDataOutEnable <= primaryRunning;
            primaryActive <= primaryRunning;
            // a ganged secondary port also shares the primary's error halt
            secondaryActive <= !enableDaisy[aspc_pkg::SECONDARY_DISABLE_BIT]
                && daisyMode != aspc_pkg::DAISY_PRIMARY
                && !(enableDaisy[aspc_pkg::FOLLOW_PRIMARY_BIT] && !primaryRunning);
            if (enableDaisy[aspc_pkg::FOLLOW_PRIMARY_BIT]) begin
                secondaryProtocol <= protocol;
                secondarySlotLength <= primaryFormat[aspc_pkg::SLOT_LENGTH_LSB +: 2];
                secondaryFrameInvert <= primaryFormat[aspc_pkg::FRAME_INVERT_BIT];
                secondaryBitInvert <= primaryFormat[aspc_pkg::BIT_CLOCK_INVERT_BIT];
            end else begin
                secondaryProtocol <= legal_code(secondaryFormat[aspc_pkg::PROTOCOL_LSB +: 2]);
                secondarySlotLength <= secondaryFormat[aspc_pkg::SLOT_LENGTH_LSB +: 2];
                secondaryFrameInvert <= secondaryFormat[aspc_pkg::FRAME_INVERT_BIT];
                secondaryBitInvert <= secondaryFormat[aspc_pkg::BIT_CLOCK_INVERT_BIT];
            end
            primaryTwoOut <= outLanes == aspc_pkg::LANE_PRIMARY_TWO;
            secondaryTwoOut <= outLanes == aspc_pkg::LANE_SECONDARY_TWO;
            primaryTwoIn <= inLanes == aspc_pkg::LANE_PRIMARY_TWO;
            secondaryTwoIn <= inLanes == aspc_pkg::LANE_SECONDARY_TWO;
            daisyPrimary <= daisyMode == aspc_pkg::DAISY_PRIMARY;
            daisySecondary <= daisyMode == aspc_pkg::DAISY_SECONDARY;
            daisyThroughInput <= laneConfig[aspc_pkg::DAISY_DIRECTION_BIT];
            // reserved input codes give a quiet low level
            case (daisySelect)
                aspc_pkg::DAISY_IN_GENERAL_ONE: daisyData <= generalOneS;
                aspc_pkg::DAISY_IN_GENERAL_TWO: daisyData <= generalTwoS;
                aspc_pkg::DAISY_IN_INPUT_ONE: daisyData <= inputOneS;
                aspc_pkg::DAISY_IN_DATA_IN: daisyData <= dataInS;
                default: daisyData <= 1'b0;
            endcase
        end
    end

    // configuration registers; reserved lane bit zero is read-only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            enableDaisy <= aspc_pkg::RST_ENABLE_DAISY;
            laneConfig <= aspc_pkg::RST_LANE_CONFIG;
            primaryFormat <= aspc_pkg::RST_PRIMARY_FORMAT;
            primaryTransmit <= aspc_pkg::RST_PRIMARY_TRANSMIT;
            secondaryFormat <= aspc_pkg::RST_SECONDARY_FORMAT;
            irqMask <= aspc_pkg::RST_IRQ_MASK;
        end else if (regWrite) begin
            case (regAddr)
                aspc_pkg::ADDR_ENABLE_DAISY: enableDaisy <= regWrData;
                aspc_pkg::ADDR_LANE_CONFIG: laneConfig <= regWrData & aspc_pkg::LANE_WRITE_MASK;
                aspc_pkg::ADDR_PRIMARY_FORMAT: primaryFormat <= regWrData;
                aspc_pkg::ADDR_PRIMARY_TRANSMIT: primaryTransmit <= regWrData;
                aspc_pkg::ADDR_SECONDARY_FORMAT: secondaryFormat <= regWrData;
                aspc_pkg::ADDR_IRQ_MASK: irqMask <= regWrData[2:0];
                default: irqMask <= irqMask;
            endcase
        end
    end

    // interrupt events; a new event beats a same-cycle write-one clear
    assign irqEvent = {rxValid, busErrorLast && !busError, busError && !busErrorLast};

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busErrorLast <= 1'b0;
            irqStatus <= 3'h0;
            irq <= 1'b0;
        end else begin
            busErrorLast <= busError;
            if (regWrite && regAddr == aspc_pkg::ADDR_IRQ_STATUS) begin
                irqStatus <= (irqStatus & ~regWrData[2:0]) | irqEvent;
            end else begin
                irqStatus <= irqStatus | irqEvent;
            end
            irq <= |(irqStatus & irqMask);
        end
    end

    // read data stands in the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            regRdData <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                aspc_pkg::ADDR_ENABLE_DAISY: regRdData <= enableDaisy;
                aspc_pkg::ADDR_LANE_CONFIG: regRdData <= laneConfig;
                aspc_pkg::ADDR_PRIMARY_FORMAT: regRdData <= primaryFormat;
                aspc_pkg::ADDR_PRIMARY_TRANSMIT: regRdData <= primaryTransmit;
                aspc_pkg::ADDR_SECONDARY_FORMAT: regRdData <= secondaryFormat;
                aspc_pkg::ADDR_IRQ_STATUS: regRdData <= {5'h00, irqStatus};
                aspc_pkg::ADDR_IRQ_MASK: regRdData <= {5'h00, irqMask};
                aspc_pkg::ADDR_PORT_STATUS: regRdData <= {5'h00, busError, primaryRunning,
                    runState == aspc_pkg::RUN_LOCKED};
                default: regRdData <= 8'h00;
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end
endmodule

//--- verif/aspc_link_model.sv
`timescale 1ns/1ps
module aspc_link_model (
    output logic bclk,
    output logic fsync,
    output logic sdata,
    input wire logic inv,
    input wire logic [3:0] slots,
    input wire logic [15:0] word
);
    int n;
    // back-to-back frames of 16-bit slots, msb first, sync high for the first half when inv is low
    // with inv low, data moves on the falling edge so it is steady at the sampling rise
    initial begin
        {bclk, fsync, sdata} = 3'h0;
        forever begin
            for (n = 0; n < 16 * slots; n++) begin
                bclk = inv;
                fsync = (n < 8 * slots) ^ inv;
                sdata = word[15 - n % 16];
                #40;
                bclk = ~inv;
                #40;
            end
        end
    end
endmodule

//--- verif/aspc_props.sv
`timescale 1ns/1ps
module aspc_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic primaryActive,
    input wire logic secondaryActive,
    input wire logic primaryTwoOut,
    input wire logic secondaryTwoOut,
    input wire logic primaryTwoIn,
    input wire logic secondaryTwoIn,
    input wire logic daisyPrimary,
    input wire logic daisySecondary,
    input wire logic daisyThroughInput
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // writes to the enable/daisy and the lane register
    sequence s_wd;
        regWrite && regAddr == 8'h18;
    endsequence
    sequence s_wl;
        regWrite && regAddr == 8'h19;
    endsequence
    // one edge stores the bit, one more lets the decode land
    chk_pri_off:
        assert property (s_wd ##0 regWrData[7] |-> ##[1:2] !primaryActive) else $error("pri on");
    chk_sec_off:
        assert property (s_wd ##0 regWrData[6] |-> ##[1:2] !secondaryActive) else $error("sec on");
    chk_daisy_one:
        assert property (!(daisyPrimary && daisySecondary)) else $error("both daisy");
    // two cycles of mode so a one-cycle skew between decodes is tolerated
    chk_daisy_pri:
        assert property (daisyPrimary [*2] |-> !secondaryActive) else $error("sec in daisy");
    chk_daisy_sec:
        assert property (daisySecondary [*2] |-> !primaryActive) else $error("pri in daisy");
    chk_out_lanes:
        assert property (!(primaryTwoOut && secondaryTwoOut)) else $error("two outs");
    chk_in_lanes:
        assert property (!(primaryTwoIn && secondaryTwoIn)) else $error("two ins");
    chk_daisy_dir:
        assert property (s_wl |-> ##2 daisyThroughInput == $past(regWrData[3], 2))
            else $error("dir bit");
endmodule
bind aspc_top aspc_props props (.clk, .sys_rst, .regAddr, .regWrData, .regWrite,
    .primaryActive, .secondaryActive, .primaryTwoOut, .secondaryTwoOut, .primaryTwoIn,
    .secondaryTwoIn, .daisyPrimary, .daisySecondary, .daisyThroughInput);

//--- verif/aspc_top_test.sv
`timescale 1ns/1ps
module aspc_top_test;
    logic clk, sys_rst, regWrite, regRead, gOne, gTwo, gIn, bclk, fsync, sdata, inv, e;
    logic rxValid, irq, priAct, secAct, dP, dS, dIn, dData, pTO, sTO, pTI, sTI, sFI, sBI, oe;
    logic [7:0] regAddr, regWrData, regRdData, d, r, fmt;
    logic [31:0] rxWord;
    logic [15:0] word;
    logic [3:0] slots;
    logic [1:0] sProt, sLen;
    int failures, numChecks, i;
    int mdl[int];
    aspc_top dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .pinBitClock(bclk),
        .pinFrameSync(fsync), .pinDataIn(sdata), .pinGeneralOne(gOne), .pinGeneralTwo(gTwo),
        .pinGeneralInputOne(gIn), .pinDataOut(), .pinDataOutEnable(oe), .txWord(32'h0),
        .txTake(), .rxWord(rxWord), .rxValid(rxValid), .primaryActive(priAct),
        .secondaryActive(secAct), .secondaryProtocol(sProt), .secondarySlotLength(sLen),
        .secondaryFrameInvert(sFI), .secondaryBitInvert(sBI), .primaryTwoOut(pTO),
        .secondaryTwoOut(sTO), .primaryTwoIn(pTI), .secondaryTwoIn(sTI), .daisyPrimary(dP),
        .daisySecondary(dS), .daisyThroughInput(dIn), .daisyData(dData), .irq(irq));
    aspc_link_model link (.bclk(bclk), .fsync(fsync), .sdata(sdata), .inv(inv),
        .slots(slots), .word(word));
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    task automatic print_verdict();
        $display("checks %0d failures %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
        numChecks++;
        if (s !== x) begin
            failures++;
            $display("BAD %s exp %h saw %h", n, x, s);
        end
    endtask
    // model keeps what software wrote below 0x30; the lane register never holds bit 0
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        {regAddr, regWrData, regWrite} <= {a, v, 1'h1};
        @(posedge clk);
        regWrite <= 1'h0;
        if (a < 8'h30) mdl[a] = (a == 8'h19) ? (v & 8'hFE) : v;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        {regAddr, regRead} <= {a, 1'h1};
        @(posedge clk);
        regRead <= 1'h0;
        #1 v = regRdData;
    endtask
    task automatic rdChk(input logic [7:0] a);
        logic [7:0] v;
        rd(a, v);
        chk("reg", mdl.exists(a) ? mdl[a] : 0, {24'h0, v});
    endtask
    // bounded wait for a received slot, or for the interrupt when ir is set
    task automatic waitEv(input bit ir);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while ((ir ? irq : rxValid) !== 1'h1 && k < 3000);
        if (k >= 3000) begin
            failures++;
            print_verdict();
        end
    endtask
    initial begin
        logic [7:0] adr [5];
        logic [2:0] din [5];
        adr = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h55};
        din = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
        mdl = '{8'h18: 8'h40, 8'h19: 8'h00, 8'h1A: 8'h30, 8'h1B: 8'h00};
        {sys_rst, regWrite, regRead, gOne, gTwo, gIn, inv} = 7'h40;
        {regAddr, regWrData, slots, word} = {16'h0, 4'h2, 16'hA5C3};
        r = 8'($urandom(32'h8FA7));
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
        foreach (adr[j]) rdChk(adr[j]);
        $display("reset test done");
        for (i = 0; i < 5; i++) begin
            r = 8'($urandom);
            {gOne, gTwo, gIn} <= {r[6], r[7], ~r[6]};
            fmt = {2'(i % 3), r[1:0], r[3:2], 2'h2};
            wr(8'h18, {i[0], i[1], r[5], 2'(i % 3), din[i]});
            wr(8'h19, {2'(i % 3), 2'((i + 1) % 3), r[4], 3'h0});
            wr(8'h1A, fmt);
            wr(8'h1B, r);
            repeat (6) @(posedge clk);
            #1;
            e = din[i] == 1 ? r[6] : din[i] == 2 ? r[7] : din[i] == 3 ? ~r[6] : 1'h0;
            if (i != 4) chk("din", e, dData);
            chk("daisy", {i % 3 == 1, i % 3 == 2}, {dP, dS});
            chk("lane", {i % 3 == 1, i % 3 == 2, (i + 1) % 3 == 1, (i + 1) % 3 == 2, r[4]},
                {pTO, sTO, pTI, sTI, dIn});
            chk("gang", r[5] ? fmt[7:2] : 6'h0C, {sProt, sLen, sFI, sBI});
            // a chained secondary removes the primary; a ganged secondary needs it running
            chk("pri", {2{!i[0] && i % 3 != 2}}, {priAct, oe});
            chk("sec", !i[1] && i % 3 != 1 && !(r[5] && (i[0] || i % 3 == 2)), secAct);
            foreach (adr[j]) rdChk(adr[j]);
        end
        $display("config test done");
        wr(8'h18, 8'h40);
        wr(8'h19, 8'h00);
        for (i = 0; i < 2; i++) begin
            {inv, word} <= {i[0], 16'($urandom)};
            wr(8'h1A, i[0] ? 8'h8E : 8'h82);
            repeat (4) waitEv(0);
            chk("rx", {16'h0, word}, rxWord);
        end
        $display("link test done");
        wr(8'h1A, 8'h81);
        wr(8'h32, 8'h01);
        wr(8'h31, 8'h07);
        repeat (4) waitEv(0);
        slots <= 4'h1;
        waitEv(1);
        rd(8'h33, d);
        chk("lock", 2'h1, {priAct, d[0]});
        // only the error-cleared event may raise the line now
        wr(8'h32, 8'h02);
        @(posedge clk);
        #1;
        chk("mask", 0, irq);
        wr(8'h31, 8'h01);
        rd(8'h31, d);
        chk("clear", 0, d[0]);
        // reconfigure only once the link is clean, or the lock comes straight back
        waitEv(1);
        wr(8'h1A, 8'h81);
        waitEv(0);
        chk("resume", 1, priAct);
        $display("error test done");
        print_verdict();
    end
endmodule
